// [tuner_pkg.sv]
// constants shared by the receive tuner: register map, field layout,
// reset values and the enumerations of modes and transfer states.
// assumes an 8-bit register address and 16-bit register data.
package tuner_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] holdoff_addr      = 8'h84;
  localparam logic [7:0] tuning_low_addr   = 8'h85;
  localparam logic [7:0] tuning_high_addr  = 8'h86;
  localparam logic [7:0] phase_offset_addr = 8'h87;
  localparam logic [7:0] osc_control_addr  = 8'h88;
  localparam logic [7:0] input_config_addr = 8'h90;
  localparam logic [7:0] status_addr       = 8'h91;
  localparam logic [7:0] gain_scale_addr   = 8'h92;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int bypass_bit       = 0;
  localparam int phase_dither_bit = 1;
  localparam int amp_dither_bit   = 2;
  localparam int clear_on_hop_bit = 3;
  localparam int loud_lsb         = 0;
  localparam int quiet_lsb        = 5;
  localparam int cfg_invert_bit   = 0;
  localparam int cfg_offset_lsb   = 1;
  localparam int cfg_mode_lsb     = 6;
  localparam int cfg_immediate_bit = 8;
  localparam int rom_addr_lsb     = 9;

  // ************************************************************
  // values after reset and arithmetic constants
  // ************************************************************
  localparam logic [15:0] word_reset    = 16'h0000;
  localparam logic [31:0] freq_reset    = 32'h0000_0000;
  localparam logic [3:0]  control_reset = 4'h0;
  localparam logic [9:0]  gain_reset    = 10'h000;
  localparam logic [15:0] lfsr_seed     = 16'hACE1;
  localparam logic [15:0] lfsr_taps     = 16'hB400;
  localparam logic [4:0]  invert_base   = 5'h07;

  // ************************************************************
  // enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    ien_blank_low  = 2'b00,
    ien_clock_high = 2'b01,
    ien_rise       = 2'b10,
    ien_fall       = 2'b11
  } ien_mode_type;

  typedef enum logic [1:0] {
    xfer_idle  = 2'b01,
    xfer_count = 2'b10
  } xfer_state_type;

endpackage : tuner_pkg

// [dither_lfsr.sv]
// pseudo-random source for phase and amplitude dither.
// assumes one clock and a synchronous active-high reset.
module dither_lfsr (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  output logic [15:0]      rand_out
);

  logic [15:0] lfsr_reg;
  logic [15:0] lfsr_next;

  // ************************************************************
  // galois shift register, never allowed to lock at zero
  // ************************************************************
  always_comb begin
    lfsr_next = {1'b0, lfsr_reg[15:1]};
    if (lfsr_reg[0]) begin
      lfsr_next = lfsr_next ^ tuner_pkg::lfsr_taps;
    end
  end

  // seed is fixed so runs repeat exactly
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lfsr_reg <= tuner_pkg::lfsr_seed;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign rand_out = lfsr_reg;

endmodule : dither_lfsr

// [sine_rom.sv]
// quarter-wave sine table giving registered cosine and sine words.
// assumes a 7-bit phase (128 steps a turn) and synchronous reset.
module sine_rom (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [6:0]  phase_addr,
  output logic [15:0]      cos_out,
  output logic [15:0]      sin_out
);

  // 32 samples of the first quadrant, taken at half-step centres
  localparam logic [32*15-1:0] quarter_table = {
    15'h7FF5, 15'h7FA6, 15'h7F09, 15'h7E1D, 15'h7CE3, 15'h7B5C, 15'h7989, 15'h776B,
    15'h7504, 15'h7255, 15'h6F5F, 15'h6C23, 15'h68A6, 15'h64E8, 15'h60EB, 15'h5CB3,
    15'h5842, 15'h539B, 15'h4EBF, 15'h49B4, 15'h447A, 15'h3F17, 15'h398C, 15'h33DF,
    15'h2E11, 15'h2826, 15'h2223, 15'h1C0B, 15'h15E2, 15'h0FAB, 15'h096A, 15'h0324};

  logic [15:0] cos_reg;
  logic [15:0] sin_reg;

  // ************************************************************
  // fold the full turn onto the quadrant table
  // ************************************************************
  function automatic logic [15:0] sine_of(input logic [6:0] ph);
    logic [4:0]  idx;
    logic [15:0] mag;
    idx = ph[5] ? ~ph[4:0] : ph[4:0];
    mag = {1'b0, quarter_table[idx*15 +: 15]};
    sine_of = ph[6] ? 16'(-mag) : mag;
  endfunction : sine_of

  // read data come out of registers, one cycle after the address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cos_reg <= tuner_pkg::word_reset;
      sin_reg <= tuner_pkg::word_reset;
    end else begin
      cos_reg <= sine_of(7'(phase_addr + 7'h20));
      sin_reg <= sine_of(phase_addr);
    end
  end

  assign cos_out = cos_reg;
  assign sin_out = sin_reg;

endmodule : sine_rom

// [exponent_scaling_and_nco_tuner.sv]
// receive front end of one channel: exponent scaling of the mantissa
// and complex down-conversion by a 32-bit oscillator.
// assumes converter inputs, input enable, level indicator, sleep exit
// and hop pulses are all synchronous to ref_clk.

module exponent_scaling_and_nco_tuner (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic [13:0] sample_a,
  input  wire logic [2:0]  exponent_a,
  input  wire logic [13:0] sample_b,
  input  wire logic [2:0]  exponent_b,
  input  wire logic        input_enable,
  input  wire logic        level_indicator_output,
  input  wire logic        sleep_exit,
  input  wire logic        sync_hop,
  output logic [15:0]      i_out,
  output logic [15:0]      q_out,
  output logic             sample_valid
);

  // ************************************************************
  // state of the block
  // ************************************************************
  typedef struct packed {
    logic [15:0]               holdoff;
    logic [31:0]               shadow_freq;
    logic [31:0]               active_freq;
    logic [15:0]               phase_offset;
    logic [3:0]                control;
    logic [9:0]                gain_scale;
    logic                      exponent_invert;
    logic [4:0]                exp_offset;
    tuner_pkg::ien_mode_type   ien_mode;
    logic                      immediate_sync;
    tuner_pkg::xfer_state_type xfer;
    logic [15:0]               count;
    logic [31:0]               acc;
    logic                      ien_prev;
    logic [15:0]               scaled_a;
    logic [15:0]               scaled_b;
    logic                      taken;
    logic [15:0]               rdata;
    logic [15:0]               i_word;
    logic [15:0]               q_word;
    logic                      valid;
  } tuner_state_type;

  tuner_state_type state_reg;
  tuner_state_type state_next;

  logic [15:0] rand_word;
  logic [15:0] cos_word;
  logic [15:0] sin_word;
  logic [15:0] phase_sum;
  logic [15:0] phase_dith;
  logic [6:0]  rom_addr;
  logic [15:0] cos_d;
  logic [15:0] sin_d;
  logic [31:0] prod_i;
  logic [31:0] prod_q;
  logic [4:0]  gain_sel;
  logic        take;
  logic        advance;
  logic        transfer_event;
  logic        do_xfer;

  // ************************************************************
  // exponent scaling
  // ************************************************************
  // the 5-bit sum wraps by itself, which gives the modulo 32
  function automatic logic [15:0] scale_sample(
    input logic [13:0] mant,
    input logic [2:0]  expo,
    input logic        inv,
    input logic [4:0]  offs,
    input logic [4:0]  gain
  );
    logic [4:0] base;
    logic [4:0] shift;
    if (inv) begin
      base = 5'(tuner_pkg::invert_base - {2'b00, expo});
    end else begin
      base = {2'b00, expo};
    end
    shift = 5'(base + offs + gain);
    scale_sample = 16'($signed({mant, 2'b00}) >>> shift);
  endfunction : scale_sample

  // ************************************************************
  // oscillator phase and dither
  // ************************************************************
  dither_lfsr dither_src (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .rand_out (rand_word)
  );

  // offset is added after the accumulator so clearing keeps it
  assign phase_sum = 16'(state_reg.acc[31:16] + state_reg.phase_offset);

  // dither lands only in the bits below the table address
  assign phase_dith = state_reg.control[tuner_pkg::phase_dither_bit]
                    ? 16'(phase_sum + {7'h00, rand_word[8:0]})
                    : phase_sum;

  assign rom_addr = phase_dith[15:tuner_pkg::rom_addr_lsb];

  sine_rom wave_table (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .phase_addr (rom_addr),
    .cos_out    (cos_word),
    .sin_out    (sin_word)
  );

  // one random lsb on each output of the table
  always_comb begin
    cos_d = cos_word;
    sin_d = sin_word;
    if (state_reg.control[tuner_pkg::amp_dither_bit]) begin
      cos_d = 16'(cos_word + {15'h0000, rand_word[15]});
      sin_d = 16'(sin_word + {15'h0000, rand_word[14]});
    end
  end

  // ************************************************************
  // the two mixers
  // ************************************************************
  // the table holds 15-bit magnitudes, so bit 30 down is the product
  always_comb begin
    prod_i = 32'($signed(state_reg.scaled_a) * $signed(cos_d));
    prod_q = 32'(-($signed(state_reg.scaled_a) * $signed(sin_d)));
  end

  // ************************************************************
  // input enable handling
  // ************************************************************
  always_comb begin
    take    = 1'b0;
    advance = 1'b0;
    case (state_reg.ien_mode)
      tuner_pkg::ien_blank_low: begin
        take    = 1'b1;
        advance = 1'b1;
      end
      tuner_pkg::ien_clock_high: begin
        take    = input_enable;
        advance = input_enable;
      end
      tuner_pkg::ien_rise: begin
        take    = input_enable & ~state_reg.ien_prev;
        advance = take;
      end
      tuner_pkg::ien_fall: begin
        take    = ~input_enable & state_reg.ien_prev;
        advance = take;
      end
      default: begin
        take    = 1'b0;
        advance = 1'b0;
      end
    endcase
  end

  assign gain_sel = level_indicator_output
                  ? state_reg.gain_scale[tuner_pkg::loud_lsb +: 5]
                  : state_reg.gain_scale[tuner_pkg::quiet_lsb +: 5];

  // ************************************************************
  // shadow to active transfer
  // ************************************************************
  assign transfer_event = sleep_exit | sync_hop;

  // a new event during a count restarts it, so the set wins
  always_comb begin
    do_xfer = 1'b0;
    case (state_reg.xfer)
      tuner_pkg::xfer_idle: begin
        if (transfer_event && state_reg.immediate_sync) begin
          do_xfer = 1'b1;
        end
      end
      tuner_pkg::xfer_count: begin
        if (transfer_event && state_reg.immediate_sync) begin
          do_xfer = 1'b1;
        end else if (!transfer_event && state_reg.count == 16'h0000) begin
          do_xfer = 1'b1;
        end
      end
      default: begin
        do_xfer = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_next       = state_reg;
    state_next.rdata = tuner_pkg::word_reset;

    // register writes
    if (reg_wr) begin
      if (reg_addr == tuner_pkg::holdoff_addr) begin
        state_next.holdoff = reg_wdata;
      end else if (reg_addr == tuner_pkg::tuning_low_addr) begin
        state_next.shadow_freq[15:0] = reg_wdata;
      end else if (reg_addr == tuner_pkg::tuning_high_addr) begin
        state_next.shadow_freq[31:16] = reg_wdata;
      end else if (reg_addr == tuner_pkg::phase_offset_addr) begin
        state_next.phase_offset = reg_wdata;
      end else if (reg_addr == tuner_pkg::osc_control_addr) begin
        state_next.control = reg_wdata[3:0];
      end else if (reg_addr == tuner_pkg::input_config_addr) begin
        state_next.exponent_invert = reg_wdata[tuner_pkg::cfg_invert_bit];
        state_next.exp_offset      = reg_wdata[tuner_pkg::cfg_offset_lsb +: 5];
        state_next.ien_mode        =
          tuner_pkg::ien_mode_type'(reg_wdata[tuner_pkg::cfg_mode_lsb +: 2]);
        state_next.immediate_sync  = reg_wdata[tuner_pkg::cfg_immediate_bit];
      end else if (reg_addr == tuner_pkg::gain_scale_addr) begin
        state_next.gain_scale = reg_wdata[9:0];
      end
    end

    // register reads, answered in the following cycle only
    if (reg_rd) begin
      if (reg_addr == tuner_pkg::holdoff_addr) begin
        state_next.rdata = state_reg.holdoff;
      end else if (reg_addr == tuner_pkg::tuning_low_addr) begin
        state_next.rdata = state_reg.shadow_freq[15:0];
      end else if (reg_addr == tuner_pkg::tuning_high_addr) begin
        state_next.rdata = state_reg.shadow_freq[31:16];
      end else if (reg_addr == tuner_pkg::phase_offset_addr) begin
        state_next.rdata = state_reg.phase_offset;
      end else if (reg_addr == tuner_pkg::osc_control_addr) begin
        state_next.rdata = {12'h000, state_reg.control};
      end else if (reg_addr == tuner_pkg::input_config_addr) begin
        state_next.rdata = {7'h00, state_reg.immediate_sync, state_reg.ien_mode,
                            state_reg.exp_offset, state_reg.exponent_invert};
      end else if (reg_addr == tuner_pkg::status_addr) begin
        state_next.rdata = {15'h0000, state_reg.xfer == tuner_pkg::xfer_count};
      end else if (reg_addr == tuner_pkg::gain_scale_addr) begin
        state_next.rdata = {6'h00, state_reg.gain_scale};
      end
    end

    // hold-off sequencing
    case (state_reg.xfer)
      tuner_pkg::xfer_idle: begin
        if (transfer_event && !state_reg.immediate_sync) begin
          state_next.count = state_reg.holdoff;
          state_next.xfer  = tuner_pkg::xfer_count;
        end
      end
      tuner_pkg::xfer_count: begin
        if (transfer_event && !state_reg.immediate_sync) begin
          state_next.count = state_reg.holdoff;
        end else if (do_xfer) begin
          state_next.xfer = tuner_pkg::xfer_idle;
        end else begin
          state_next.count = 16'(state_reg.count - 16'h0001);
        end
      end
      default: begin
        state_next.xfer = tuner_pkg::xfer_idle;
      end
    endcase

    // the copy uses the shadow as it stands, so the last write wins
    if (do_xfer) begin
      state_next.active_freq = state_reg.shadow_freq;
    end

    // phase accumulator, clearing at a transfer when asked
    if (do_xfer && state_reg.control[tuner_pkg::clear_on_hop_bit]) begin
      state_next.acc = tuner_pkg::freq_reset;
    end else if (advance) begin
      state_next.acc = 32'(state_reg.acc + state_reg.active_freq);
    end

    // input sampling and scaling
    state_next.ien_prev = input_enable;
    state_next.taken    = take;
    if (take) begin
      if (state_reg.ien_mode == tuner_pkg::ien_blank_low && !input_enable) begin
        state_next.scaled_a = tuner_pkg::word_reset;
        state_next.scaled_b = tuner_pkg::word_reset;
      end else begin
        state_next.scaled_a = scale_sample(sample_a, exponent_a,
          state_reg.exponent_invert, state_reg.exp_offset, gain_sel);
        state_next.scaled_b = scale_sample(sample_b, exponent_b,
          state_reg.exponent_invert, state_reg.exp_offset, gain_sel);
      end
    end

    // mixer outputs, one cycle behind the scaled sample
    state_next.valid = state_reg.taken;
    if (state_reg.control[tuner_pkg::bypass_bit]) begin
      state_next.i_word = state_reg.scaled_a;
      state_next.q_word = state_reg.scaled_b;
    end else begin
      state_next.i_word = prod_i[30:15];
      state_next.q_word = prod_q[30:15];
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg                 <= '0;
      state_reg.holdoff         <= tuner_pkg::word_reset;
      state_reg.shadow_freq     <= tuner_pkg::freq_reset;
      state_reg.active_freq     <= tuner_pkg::freq_reset;
      state_reg.phase_offset    <= tuner_pkg::word_reset;
      state_reg.control         <= tuner_pkg::control_reset;
      state_reg.gain_scale      <= tuner_pkg::gain_reset;
      state_reg.ien_mode        <= tuner_pkg::ien_blank_low;
      state_reg.xfer            <= tuner_pkg::xfer_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output comes straight from the state register
  assign reg_rdata    = state_reg.rdata;
  assign i_out        = state_reg.i_word;
  assign q_out        = state_reg.q_word;
  assign sample_valid = state_reg.valid;

endmodule : exponent_scaling_and_nco_tuner

// [tuner_sva.sv]
// checker for the receive tuner: read data timing and the sample
// strobe of each input mode. assumes it is bound to the tuner top.
module tuner_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        input_enable,
  input wire logic [15:0] i_out,
  input wire logic [15:0] q_out,
  input wire logic        sample_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_reg;

  // ********************
  // mode tracking
  // ********************
  // copy of the input mode field, so the strobe checks follow software
  always_ff @(posedge ref_clk) begin
    if (rst)
      mode_reg <= 2'h0;
    else if (reg_wr && reg_addr == tuner_pkg::input_config_addr)
      mode_reg <= reg_wdata[7:6];
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ********************
  // properties
  // ********************
  sequence valid_in_two;
    ##2 sample_valid;
  endsequence
  sequence quiet_in_two;
    ##2 !sample_valid;
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside its slot");
  unmapped_read_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  blank_take_a: assert property (mode_reg == 2'h0 && !$past(rst) |-> valid_in_two)
    else $error("blank mode missed a sample");
  blank_zero_a: assert property (mode_reg == 2'h0 && !input_enable && !$past(rst)
    |-> ##2 (i_out == 16'h0000 && q_out == 16'h0000))
    else $error("blanked sample not zero");
  high_take_a: assert property (mode_reg == 2'h1 && input_enable |-> valid_in_two)
    else $error("enable high sample missed");
  high_hold_a: assert property (mode_reg == 2'h1 && !input_enable |-> quiet_in_two)
    else $error("sample taken with enable low");
  rise_take_a: assert property (mode_reg == 2'h2 && $rose(input_enable) |-> valid_in_two)
    else $error("rising enable sample missed");
  rise_once_a: assert property (mode_reg == 2'h2 && !$rose(input_enable) |-> quiet_in_two)
    else $error("extra sample in rise mode");
  fall_take_a: assert property (mode_reg == 2'h3 && $fell(input_enable) |-> valid_in_two)
    else $error("falling enable sample missed");
  fall_once_a: assert property (mode_reg == 2'h3 && !$fell(input_enable) |-> quiet_in_two)
    else $error("extra sample in fall mode");
endmodule : tuner_sva

// [adc_model.sv]
// model of the converter ahead of the tuner: holds mantissa and
// exponent, strobes input enable once every rate+1 clocks.
// assumes the bench changes its levels just after a rising edge.
module adc_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  rate,
  input  wire logic [13:0] mant,
  input  wire logic [2:0]  expo,
  output logic [13:0]      sample_a,
  output logic [2:0]       exponent_a,
  output logic [13:0]      sample_b,
  output logic [2:0]       exponent_b,
  output logic             input_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;

  // strobe counter; rate zero keeps enable high every clock
  always_ff @(posedge ref_clk) begin
    if (rst || cnt_reg == rate)
      cnt_reg <= 2'h0;
    else
      cnt_reg <= cnt_reg + 2'h1;
  end

  // between strobes the lines show the inverse, so stale data never passes
  assign input_enable = !rst && cnt_reg == 2'h0;
  assign sample_a     = input_enable ? mant : ~mant;
  assign sample_b     = input_enable ? -mant : mant;
  assign exponent_a   = expo;
  assign exponent_b   = expo;
endmodule : adc_model

// [exponent_scaling_and_nco_tuner_tb_top.sv]
// self-checking bench for the receive tuner: registers, scaling,
// input modes and oscillator transfers. assumes one 100 MHz clock.
module exponent_scaling_and_nco_tuner_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, reg_wr, reg_rd, lvl_in, sleep_exit, sync_hop, en;
  logic        sample_valid;
  logic [1:0]  rate;
  logic [2:0]  expo, exp_a, exp_b;
  logic [7:0]  reg_addr;
  logic [13:0] mant, smp_a, smp_b;
  logic [15:0] reg_wdata, reg_rdata, i_out, q_out;
  int          n_fail, total_checks;

  // ********************
  // clock, model, design
  // ********************
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  adc_model u_adc (.ref_clk(ref_clk), .rst(rst), .rate(rate), .mant(mant), .expo(expo),
    .sample_a(smp_a), .exponent_a(exp_a), .sample_b(smp_b), .exponent_b(exp_b),
    .input_enable(en));

  exponent_scaling_and_nco_tuner u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_a(smp_a), .exponent_a(exp_a), .sample_b(smp_b), .exponent_b(exp_b),
    .input_enable(en), .level_indicator_output(lvl_in), .sleep_exit(sleep_exit),
    .sync_hop(sync_hop), .i_out(i_out), .q_out(q_out), .sample_valid(sample_valid));

  // ********************
  // shared tasks
  // ********************
  task conclude;
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge ref_clk);
    reg_wr    <= 1'h0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge ref_clk);
    reg_rd   <= 1'h0;
    #1 chk("rdata", e, reg_rdata);
  endtask : rd

  task cfg(input logic inv, input logic [4:0] off, input logic [1:0] m, input logic imm);
    wr(tuner_pkg::input_config_addr, {7'h00, imm, m, off, inv});
  endtask : cfg

  function automatic logic [15:0] sc(input logic [13:0] m, input logic [4:0] s);
    return $signed({m, 2'h0}) >>> s;
  endfunction : sc

  // ********************
  // scenarios
  // ********************
  task regs_case;
    logic [7:0]  ra [7];
    logic [15:0] rm [7];
    ra = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h90, 8'h92};
    rm = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h000F, 16'h01FF, 16'h03FF};
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], 16'h0000);
      wr(ra[i], 16'hA5A5);
      rd(ra[i], 16'hA5A5 & rm[i]);
    end
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 16'h0000);
    wr(tuner_pkg::status_addr, 16'hFFFF);
    rd(tuner_pkg::status_addr, 16'h0000);
  endtask : regs_case

  // bypass on, so i and q show the scaled a and b samples directly
  task scale_case(input logic inv, input logic [4:0] off, input logic l, input logic [2:0] e);
    logic [4:0] s;
    s = (inv ? 5'h07 - {2'h0, e} : {2'h0, e}) + off + (l ? 5'h02 : 5'h00);
    cfg(inv, off, 2'h0, 1'h0);
    expo <= e;
    lvl_in <= l;
    cyc(4);
    chk("i_scaled", sc(mant, s), i_out);
    chk("q_scaled", sc(-mant, s), q_out);
  endtask : scale_case

  task modes_case;
    int n;
    rate <= 2'h3;
    for (int m = 0; m < 4; m++) begin
      cfg(1'h1, 5'h1E, m[1:0], 1'h0);
      cyc(2);
      n = 0;
      repeat (16) begin
        @(posedge ref_clk);
        #1;
        if (sample_valid === 1'h1)
          n++;
      end
      chk("valid_count", (m == 0) ? 16'h0010 : 16'h0004, n[15:0]);
    end
    rate <= 2'h0;
    cfg(1'h1, 5'h1E, 2'h0, 1'h0);
  endtask : modes_case

  task nco_case;
    logic [15:0] v;
    expo <= 3'h5;
    lvl_in <= 1'h0;
    wr(tuner_pkg::osc_control_addr, 16'h0000);
    // the register test left an offset behind; start the oscillator from zero phase
    wr(tuner_pkg::phase_offset_addr, 16'h0000);
    wr(tuner_pkg::holdoff_addr, 16'h0004);
    wr(tuner_pkg::tuning_high_addr, 16'h4000);
    wr(tuner_pkg::tuning_low_addr, 16'h0000);
    cyc(4);
    v = i_out;
    chk("i_sign", 16'h0000, {15'h0, i_out[15]});
    cyc(1);
    chk("i_held", v, i_out);
    @(posedge ref_clk);
    sleep_exit <= 1'h1;
    @(posedge ref_clk);
    sleep_exit <= 1'h0;
    #1 v = i_out;
    rd(tuner_pkg::status_addr, 16'h0001);
    chk("i_before_copy", v, i_out);
    // a half turn a clock must win over the quarter turn written first
    wr(tuner_pkg::tuning_high_addr, 16'h8000);
    cyc(8);
    v = i_out;
    cyc(1);
    chk("i_toggle", {15'h0, ~v[15]}, {15'h0, i_out[15]});
    rd(tuner_pkg::status_addr, 16'h0000);
    wr(tuner_pkg::osc_control_addr, 16'h0008);
    cfg(1'h1, 5'h1E, 2'h0, 1'h1);
    wr(tuner_pkg::tuning_high_addr, 16'h0000);
    @(posedge ref_clk);
    sync_hop <= 1'h1;
    @(posedge ref_clk);
    sync_hop <= 1'h0;
    rd(tuner_pkg::status_addr, 16'h0000);
    cyc(4);
    v = i_out;
    chk("i_cleared", 16'h0000, {15'h0, i_out[15]});
    chk("q_sign", 16'h0001, {15'h0, q_out[15]});
    cyc(1);
    chk("i_stopped", v, i_out);
    wr(tuner_pkg::phase_offset_addr, 16'h8000);
    cyc(4);
    chk("i_offset", 16'h0001, {15'h0, i_out[15]});
    wr(tuner_pkg::phase_offset_addr, 16'h0000);
    for (int d = 0; d < 4; d++) begin
      wr(tuner_pkg::osc_control_addr, {13'h0000, d[1:0], 1'h0});
      cyc(4);
      chk("i_dither", 16'h0000, {15'h0, i_out[15]});
    end
  endtask : nco_case

  // ********************
  // main sequence
  // ********************
  initial begin
    n_fail = 0;
    total_checks = 0;
    rst = 1'h1;
    {reg_wr, reg_rd, lvl_in, sleep_exit, sync_hop} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    rate = 2'h0;
    mant = 14'h0A5C;
    expo = 3'h0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    cyc(1);
    regs_case;
    wr(tuner_pkg::osc_control_addr, 16'h0001);
    wr(tuner_pkg::gain_scale_addr, 16'h0002);
    for (int e = 5; e >= 0; e--)
      scale_case(1'h1, 5'h1E, 1'h0, e[2:0]);
    scale_case(1'h0, 5'h00, 1'h0, 3'h5);
    scale_case(1'h1, 5'h1E, 1'h1, 3'h5);
    scale_case(1'h0, 5'h1E, 1'h1, 3'h4);
    modes_case;
    nco_case;
    conclude;
  end

  // hang guard at 50000 clocks, far beyond what the whole run needs
  initial begin
    repeat (50000) @(posedge ref_clk);
    n_fail++;
    conclude;
  end
endmodule : exponent_scaling_and_nco_tuner_tb_top

bind exponent_scaling_and_nco_tuner tuner_sva u_sva (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .input_enable(input_enable), .i_out(i_out), .q_out(q_out),
  .sample_valid(sample_valid));
